// ---- src/tbp_host.sv ----
// host controller: runs stretched adapter accesses and port setup
`timescale 1ns/1ns
module tbp_host (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  tbp_link_if.host         link,
  input  wire logic [1:0]  sw_addr,
  input  wire logic [7:0]  sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [7:0]  sw_rdata
);
  typedef enum {ST_IDLE, ST_ACC, ST_CAP, ST_DONE, ST_CFG_RD, ST_CFG_CMP,
    ST_CFG_WR, ST_B_WR} tbp_state_e;
  tbp_state_e  state_reg;
  logic [7:0]  data_reg;
  logic [15:0] addr_reg;
  logic [7:0]  res_reg;
  logic [7:0]  cfg_reg;
  logic        is_wr_reg;
  logic        busy_reg;
  logic [3:0]  cnt_reg;
  logic [7:0]  sw_rdata_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      busy_reg  <= 1'b0;
      is_wr_reg <= 1'b0;
      res_reg   <= 8'h00;
      cfg_reg   <= tbp_pkg::CTRL_RESET;
      addr_reg  <= tbp_pkg::PORT_A_ADDR;
      data_reg  <= 8'h00;
      link.addr <= 16'h0000;
      link.wdata <= 8'h00;
      link.wr   <= 1'b0;
      link.rd   <= 1'b0;
    end else begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      if (sw_wr && sw_addr == tbp_pkg::HREG_DATA) data_reg <= sw_wdata;
      if (sw_wr && sw_addr == tbp_pkg::HREG_ADDR)
        addr_reg <= tbp_pkg::PORT_A_ADDR + {14'h0000, sw_wdata[1:0]};
      case (state_reg)
        ST_IDLE: begin
          // commands are taken only when idle: no access is split
          if (sw_wr && sw_addr == tbp_pkg::HREG_CMD) begin
            busy_reg <= 1'b1;
            cnt_reg  <= 4'(tbp_pkg::STRETCH_CYCLES);
            if (sw_wdata[tbp_pkg::CMD_SETUP_BIT]) begin
              // B output, lower C input, others by flags
              cfg_reg <= tbp_pkg::CTRL_BASE
                | {3'b000, ~sw_wdata[tbp_pkg::CMD_A_OUT_BIT], 4'h0}
                | {4'h0, ~sw_wdata[tbp_pkg::CMD_CU_OUT_BIT], 3'b000};
              link.addr <= tbp_pkg::CTRL_ADDR;
              link.rd   <= 1'b1;
              state_reg <= ST_CFG_RD;
            end else begin
              is_wr_reg <= sw_wdata[tbp_pkg::CMD_WRITE_BIT];
              link.addr <= addr_reg;
              link.wdata <= data_reg;
              link.wr   <= sw_wdata[tbp_pkg::CMD_WRITE_BIT];
              link.rd   <= sw_wdata[tbp_pkg::CMD_READ_BIT];
              state_reg <= ST_ACC;
            end
          end
        end
        // read data stands only from the edge after the strobe is taken
        ST_ACC: state_reg <= ST_CAP;
        ST_CAP: begin
          if (!is_wr_reg) res_reg <= link.rdata;
          state_reg <= ST_DONE;
        end
        ST_DONE: begin
          // stretched cycle: hold off the next access
          if (cnt_reg == 4'h0) begin
            busy_reg  <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_CFG_RD: begin
          // setup accesses keep the same stretch gap
          if (cnt_reg == 4'h0) begin
            state_reg <= ST_CFG_CMP;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_CFG_CMP: begin
          cnt_reg <= 4'(tbp_pkg::STRETCH_CYCLES);
          if (link.rdata == cfg_reg) begin
            state_reg <= ST_B_WR;
          end else begin
            link.addr  <= tbp_pkg::CTRL_ADDR;
            link.wdata <= cfg_reg;
            link.wr    <= 1'b1;
            state_reg  <= ST_CFG_WR;
          end
        end
        ST_CFG_WR: begin
          if (cnt_reg == 4'h0) begin
            state_reg <= ST_B_WR;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_B_WR: begin
          cnt_reg    <= 4'(tbp_pkg::STRETCH_CYCLES);
          link.addr  <= tbp_pkg::PORT_B_ADDR;
          link.wdata <= tbp_pkg::B_INIT_VALUE;
          link.wr    <= 1'b1;
          is_wr_reg  <= 1'b1;
          state_reg  <= ST_ACC;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sw_rdata_reg <= 8'h00;
    end else if (sw_rd) begin
      case (sw_addr)
        tbp_pkg::HREG_STATUS: sw_rdata_reg <= {7'h00, busy_reg};
        tbp_pkg::HREG_DATA:   sw_rdata_reg <= res_reg;
        tbp_pkg::HREG_ADDR:   sw_rdata_reg <= {6'h00, addr_reg[1:0]};
        default:              sw_rdata_reg <= cfg_reg;
      endcase
    end
  end
  assign sw_rdata = sw_rdata_reg;
endmodule

// ---- src/tbp_pkg.sv ----
// shared constants for the triple byte parallel io adapter
package tbp_pkg;
  localparam logic [15:0] PORT_A_ADDR   = 16'h8080;
  localparam logic [15:0] PORT_B_ADDR   = 16'h8081;
  localparam logic [15:0] PORT_C_ADDR   = 16'h8082;
  localparam logic [15:0] CTRL_ADDR     = 16'h8083;
  // control byte fields: mode-set flag, mode 0, direction bits (1 = input)
  localparam int          CTRL_SET_BIT  = 7;
  localparam int          CTRL_A_IN_BIT = 4;
  localparam int          CTRL_CU_IN_BIT = 3;
  localparam int          CTRL_B_IN_BIT = 1;
  localparam int          CTRL_CL_IN_BIT = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h99;
  localparam logic [7:0]  CTRL_BASE     = 8'h81;
  localparam logic [7:0]  B_INIT_VALUE  = 8'h80;
  localparam int          STRETCH_TIME_NS = 300;
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          STRETCH_CYCLES =
    (STRETCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // host command register map
  localparam logic [1:0]  HREG_CMD      = 2'h0;
  localparam logic [1:0]  HREG_STATUS   = 2'h1;
  localparam logic [1:0]  HREG_DATA     = 2'h2;
  localparam logic [1:0]  HREG_ADDR     = 2'h3;
  localparam int          CMD_WRITE_BIT = 0;
  localparam int          CMD_READ_BIT  = 1;
  localparam int          CMD_SETUP_BIT = 2;
  localparam int          CMD_A_OUT_BIT = 3;
  localparam int          CMD_CU_OUT_BIT = 4;
endpackage

// ---- src/tbp_link_if.sv ----
// bus between the host controller and the parallel io adapter
`timescale 1ns/1ns
interface tbp_link_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  modport dev  (input addr, wdata, wr, rd, output rdata);
  modport host (output addr, wdata, wr, rd, input rdata);
endinterface

// ---- src/tbp_adapter.sv ----
// parallel io adapter: three byte ports, control register, bus hold
`timescale 1ns/1ns
// What this block does
// - reset: A, C nibbles input, B output
// - control register at 0x8083
// - port data at 0x8080 to 0x8082
// - any control write clears every output latch
// - mode 0 plain latched input and output
// - host sets A, upper C by flags
// - host skips control write when unchanged
// - host sets B bit6 low, bit7 high
// - input pins held high after reset/config
// - port A hold keeps last level
// - host stretches every adapter access
// - host does read-modify-write uninterrupted
// - host configures on each setup command
module tbp_adapter (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  tbp_link_if.dev   link,
  input  wire logic [23:0] pin_in,
  output logic      [23:0] pin_out,
  output logic      [23:0] pin_oe,
  output logic      [23:0] hold_high,
  output logic      [7:0]  hold_low
);
  logic [7:0]  ctrl_reg;
  logic [23:0] latch_reg;
  logic [23:0] meta_reg;
  logic [23:0] sync_reg;
  logic [7:0]  a_hold_reg;
  logic [7:0]  rdata_reg;
  logic [23:0] dir_out;

  // output mask from control direction bits
  always_comb begin
    dir_out[7:0]   = {8{~ctrl_reg[tbp_pkg::CTRL_A_IN_BIT]}};
    dir_out[15:8]  = {8{~ctrl_reg[tbp_pkg::CTRL_B_IN_BIT]}};
    dir_out[19:16] = {4{~ctrl_reg[tbp_pkg::CTRL_CL_IN_BIT]}};
    dir_out[23:20] = {4{~ctrl_reg[tbp_pkg::CTRL_CU_IN_BIT]}};
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_reg <= tbp_pkg::CTRL_RESET;
    end else if (link.wr && link.addr == tbp_pkg::CTRL_ADDR) begin
      ctrl_reg <= link.wdata | 8'h80;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      latch_reg <= 24'h00_0000;
    end else if (link.wr && link.addr == tbp_pkg::CTRL_ADDR) begin
      latch_reg <= 24'h00_0000;
    end else if (link.wr && link.addr == tbp_pkg::PORT_A_ADDR) begin
      latch_reg[7:0] <= link.wdata;
    end else if (link.wr && link.addr == tbp_pkg::PORT_B_ADDR) begin
      latch_reg[15:8] <= link.wdata;
    end else if (link.wr && link.addr == tbp_pkg::PORT_C_ADDR) begin
      latch_reg[23:16] <= link.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // pins sit high under the bus hold; no false low reaches port A hold
      meta_reg <= 24'hFF_FFFF;
      sync_reg <= 24'hFF_FFFF;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  // port A hold follows the last seen level; high after reset/config
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      a_hold_reg <= 8'hFF;
    end else if (link.wr && link.addr == tbp_pkg::CTRL_ADDR) begin
      a_hold_reg <= 8'hFF;
    end else begin
      a_hold_reg <= sync_reg[7:0];
    end
  end

  assign pin_out   = latch_reg & dir_out;
  assign pin_oe    = dir_out;
  assign hold_high = {~dir_out[23:8], ~dir_out[7:0] & a_hold_reg};
  assign hold_low  = ~dir_out[7:0] & ~a_hold_reg;

  // pin level on input bits, latch value on output bits
  function automatic logic [7:0] port_view(input logic [7:0] lat,
                                           input logic [7:0] pin,
                                           input logic [7:0] dir);
    return (lat & dir) | (pin & ~dir);
  endfunction

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (link.rd) begin
      case (link.addr)
        tbp_pkg::PORT_A_ADDR: rdata_reg <=
          port_view(latch_reg[7:0], sync_reg[7:0], dir_out[7:0]);
        tbp_pkg::PORT_B_ADDR: rdata_reg <=
          port_view(latch_reg[15:8], sync_reg[15:8], dir_out[15:8]);
        tbp_pkg::PORT_C_ADDR: rdata_reg <=
          port_view(latch_reg[23:16], sync_reg[23:16], dir_out[23:16]);
        tbp_pkg::CTRL_ADDR:   rdata_reg <= ctrl_reg;
        default:              rdata_reg <= 8'h00;
      endcase
    end
  end
  assign link.rdata = rdata_reg;
endmodule

// ---- testbench/tbp_props.sv ----
// concurrent checks on the adapter link and pins
`timescale 1ns/1ns
module tbp_props (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic [23:0] pin_in,
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] hold_high,
  input wire logic [7:0]  hold_low
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  chk_reset_dirs: assert property (
    $past(sys_rst) |-> pin_oe == 24'h00_FF00)
    else $error("pin directions wrong after reset");
  chk_ctrl_clears: assert property (
    wr && addr == tbp_pkg::CTRL_ADDR |=> pin_out == 24'h00_0000)
    else $error("outputs not cleared by control write");
  chk_b_write: assert property (
    wr && addr == tbp_pkg::PORT_B_ADDR |=> pin_out[15:8] == $past(wdata))
    else $error("second byte port latch wrong");
  chk_hold_inputs: assert property (
    hold_high[23:8] == ~pin_oe[23:8])
    else $error("input pins not held high");
  chk_hold_port_a: assert property (
    (!sys_rst && !(wr && addr == tbp_pkg::CTRL_ADDR)
      && $stable(pin_in[7:0])) [*4] ##0 !pin_oe[0]
    |-> hold_low == ~pin_in[7:0])
    else $error("first port low hold wrong");
  chk_stretch_gap: assert property (
    (wr || rd) |=> !(wr || rd) [*3])
    else $error("adapter access not stretched");
  chk_c_read: assert property (
    $stable(pin_in[19:16]) [*4] ##0 (rd && addr == tbp_pkg::PORT_C_ADDR)
    |=> rdata[3:0] == pin_in[19:16])
    else $error("lower nibble read not pin level");
  chk_b_read: assert property (
    rd && addr == tbp_pkg::PORT_B_ADDR |=> rdata == pin_out[15:8])
    else $error("output port read not latch value");

  cover property (wr && addr == tbp_pkg::CTRL_ADDR);
  cover property (rd && addr == tbp_pkg::PORT_C_ADDR);
  cover property (wr && addr == tbp_pkg::PORT_B_ADDR);
endmodule

// ---- testbench/test_triple_byte_parallel_io.sv ----
// self-checking bench: host controller and adapter joined by the link
`timescale 1ns/1ns
module test_triple_byte_parallel_io;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic [1:0]  sw_addr  = 2'h0;
  logic [7:0]  sw_wdata = 8'h00;
  logic        sw_wr    = 1'b0;
  logic        sw_rd    = 1'b0;
  logic [7:0]  sw_rdata;
  logic [23:0] pin_in   = 24'hA5_FF3C;
  logic [23:0] pin_out;
  logic [23:0] pin_oe;
  logic [23:0] hold_high;
  logic [7:0]  hold_low;
  logic [7:0]  rd_val;
  int          errors   = 0;
  int          compares = 0;

  tbp_link_if link ();
  tbp_adapter tbp_adapter_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(link), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .hold_high(hold_high), .hold_low(hold_low));
  tbp_host tbp_host_i (.core_clk(core_clk), .sys_rst(sys_rst), .link(link),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata));
  tbp_props tbp_props_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
    .rdata(link.rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .hold_high(hold_high), .hold_low(hold_low));

  always #50 core_clk = ~core_clk;

  task automatic check(string what, logic [23:0] exp, logic [23:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sw_write(logic [1:0] a, logic [7:0] d);
    @(posedge core_clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge core_clk);
    sw_wr    <= 1'b0;
  endtask
  task automatic sw_read(logic [1:0] a);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge core_clk);
    sw_rd   <= 1'b0;
    #1 rd_val = sw_rdata;
  endtask
  // issue a command and poll busy under a bounded count
  task automatic run(logic [7:0] cmd);
    sw_write(tbp_pkg::HREG_CMD, cmd);
    for (int i = 0; i < 40; i++) begin
      sw_read(tbp_pkg::HREG_STATUS);
      if (rd_val[0] === 1'b0) break;
    end
    check("busy", 24'h00_0000, {23'h00_0000, rd_val[0]});
  endtask
  task automatic port_wr(logic [1:0] p, logic [7:0] d);
    sw_write(tbp_pkg::HREG_ADDR, p);
    sw_write(tbp_pkg::HREG_DATA, d);
    run(8'h01);
  endtask
  task automatic port_rd(logic [1:0] p, logic [7:0] exp, string what);
    sw_write(tbp_pkg::HREG_ADDR, p);
    run(8'h02);
    sw_read(tbp_pkg::HREG_DATA);
    check(what, {16'h0000, exp}, {16'h0000, rd_val});
  endtask

  task automatic t_reset();
    check("oe", 24'h00_FF00, pin_oe);
    check("hold", 24'hFF_0000, hold_high & 24'hFF_FF00);
    port_rd(2'h0, 8'h3C, "port a");
    port_rd(2'h2, 8'hA5, "port c");
    check("hold a", 24'hFF_003C, hold_high);
    check("hold low", 24'h00_00C3, {16'h0000, hold_low});
  endtask
  task automatic t_busy();
    sw_write(tbp_pkg::HREG_ADDR, 8'h00);
    sw_write(tbp_pkg::HREG_DATA, 8'h5A);
    sw_write(tbp_pkg::HREG_CMD, 8'h01);
    sw_write(tbp_pkg::HREG_DATA, 8'h11);
    sw_write(tbp_pkg::HREG_CMD, 8'h01);
    run(8'h00);
    check("busy refuse", 24'h00_005A, pin_out & 24'h00_00FF);
  endtask
  task automatic t_restart();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check("oe", 24'h00_FF00, pin_oe);
    check("out", 24'h00_0000, pin_out);
    check("hold", 24'hFF_00FF, hold_high);
  endtask
  task automatic t_setup();
    run(8'h1C);
    check("oe", 24'hF0_FFFF, pin_oe);
    check("out", 24'h00_8000, pin_out);
    port_rd(2'h3, 8'h81, "ctrl");
  endtask
  task automatic t_write();
    port_wr(2'h0, 8'h5A);
    port_wr(2'h2, 8'hF0);
    port_wr(2'h1, 8'h17);
    check("out", 24'hF0_175A, pin_out);
    port_rd(2'h1, 8'h17, "port b");
    port_rd(2'h2, 8'hF5, "port c mix");
  endtask
  task automatic t_reconfig();
    run(8'h1C);
    check("out", 24'hF0_805A, pin_out);
    port_wr(2'h3, 8'h81);
    check("out", 24'h00_0000, pin_out);
    run(8'h04);
    check("oe", 24'h00_FF00, pin_oe);
    check("hold", 24'hFF_0000, hold_high & 24'hFF_FF00);
  endtask

  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_reset();
    t_setup();
    t_write();
    t_busy();
    t_reconfig();
    t_restart();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    print_verdict();
  end
endmodule
